// *** rtl/fsrsp_host.sv ***
`timescale 1ns/100ps
module fsrsp_host (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic flashCeN,
    output logic flashWeN,
    output logic flashOeN,
    output logic flashRstN,
    output logic [15:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [15:0] flashDqIn,
    input wire logic statusOutPin,
    input wire logic hwResetReq
);
    //------------------------------------------------------------
    // reset and pin synchronisers
    //------------------------------------------------------------
    logic [1:0] rstPipe;
    logic rstSync_n;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe[1];
    logic [1:0] pinMeta;
    logic [15:0] dqMeta;
    logic [15:0] dqSync;
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pinMeta <= 2'b11;
            dqMeta <= '0;
            dqSync <= '0;
        end else begin
            pinMeta <= {pinMeta[0], statusOutPin};
            dqMeta <= flashDqIn;
            dqSync <= dqMeta;
        end
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_W1, ST_W2, ST_RD, ST_DONE
    } fsrsp_state_e;
    typedef struct packed {
        fsrsp_state_e st;
        logic [3:0] op;
        logic [7:0] cfg;
        logic [7:0] cfgPend;
        logic [7:0] sreg;
        logic [15:0] raw;
        logic cfgRej;
        logic opDone;
        logic [15:0] pulseCnt;
        logic [15:0] pulseLen;
        logic pinPrev;
        logic stbGo;
        logic stbRd;
        logic [15:0] dq;
        logic dqOe;
        logic rstPin;
        logic [31:0] rdata;
    } fsrsp_host_s;
    fsrsp_host_s q, d;
    logic stbBusy, stbN, stbSample;
    fsrsp_strobe u_strobe (
        .clk_sys(clk_sys),
        .rstSync_n(rstSync_n),
        .start(q.stbGo),
        .isRead(q.stbRd),
        .busy(stbBusy),
        .strobeN(stbN),
        .sampleNow(stbSample)
    );

    function automatic logic cfgValid(input logic [7:0] code);
        cfgValid = (code[1:0] != fsrsp_pkg::CFG_PROG_ONLY);
    endfunction

    logic wrEn, rdEn, pinLvl;
    assign pinLvl = pinMeta[1];
    assign wrEn = psel && penable && pwrite;
    // read data is latched in the setup cycle so it stands for the access
    assign rdEn = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    //------------------------------------------------------------
    // command sequencer; host refuses config unless ready and not suspended, device flags invalid codes
    //------------------------------------------------------------
    always_comb begin
        d = q;
        d.stbGo = 1'b0;
        d.pinPrev = pinLvl;
        d.rstPin = !hwResetReq;
        // pulse length measure while pin low in pulse mode
        if (!pinLvl) begin
            d.pulseCnt = q.pulseCnt + 16'h0001;
        end else begin
            d.pulseCnt = '0;
        end
        if (pinLvl && !q.pinPrev && q.cfg[1:0] != 2'b00) begin
            d.pulseLen = q.pulseCnt;
        end
        // reset input returns pin to level mode
        if (hwResetReq) begin
            d.cfg = fsrsp_pkg::CFG_RESET;
        end
        unique case (q.st)
            ST_IDLE: begin
                if (wrEn && paddr == fsrsp_pkg::OFF_CTRL && !hwResetReq) begin
                    d.op = pwdata[3:0];
                    d.opDone = 1'b0;
                    d.cfgRej = 1'b0;
                    d.dqOe = 1'b1;
                    d.stbGo = 1'b1;
                    d.stbRd = 1'b0;
                    d.st = ST_W1;
                    unique case (pwdata[3:0])
                        fsrsp_pkg::OP_SUSPEND: d.dq = fsrsp_pkg::CMD_SUSPEND;
                        fsrsp_pkg::OP_RESUME: d.dq = fsrsp_pkg::CMD_RESUME;
                        fsrsp_pkg::OP_CONFIG: begin
                            d.dq = fsrsp_pkg::CMD_CFG_SETUP;
                            // only when ready; reserved bits dropped
                            if (!q.sreg[fsrsp_pkg::SR_READY] ||
                                q.sreg[fsrsp_pkg::SR_ERS_SUSP] ||
                                q.sreg[fsrsp_pkg::SR_PRG_SUSP]) begin
                                d.cfgRej = 1'b1;
                                d.stbGo = 1'b0;
                                d.dqOe = 1'b0;
                                d.st = ST_IDLE;
                                d.opDone = 1'b1;
                            end
                        end
                        fsrsp_pkg::OP_READSR: d.dq = fsrsp_pkg::CMD_READ_STATUS;
                        fsrsp_pkg::OP_CLEARSR: d.dq = fsrsp_pkg::CMD_CLEAR_STATUS;
                        fsrsp_pkg::OP_RAW: d.dq = pwdata[31:16];
                        default: begin
                            d.stbGo = 1'b0;
                            d.dqOe = 1'b0;
                            d.st = ST_IDLE;
                            d.opDone = 1'b1;
                        end
                    endcase
                end else if (wrEn && paddr == fsrsp_pkg::OFF_CFG) begin
                    d.cfgPend = pwdata[7:0] & fsrsp_pkg::CFG_FIELD_MASK;
                end
            end
            ST_W1: begin
                if (!q.stbGo && !stbBusy) begin
                    if (q.op == fsrsp_pkg::OP_CONFIG) begin
                        d.dq = {8'h00, q.cfgPend};
                        d.stbGo = 1'b1;
                        d.st = ST_W2;
                    end else if (q.op == fsrsp_pkg::OP_CLEARSR ||
                                 q.op == fsrsp_pkg::OP_RAW) begin
                        d.dqOe = 1'b0;
                        d.st = ST_DONE;
                    end else begin
                        // suspend, resume and status read all end with a status read
                        d.dqOe = 1'b0;
                        d.stbGo = 1'b1;
                        d.stbRd = 1'b1;
                        d.st = ST_RD;
                    end
                end
            end
            ST_W2: begin
                if (!q.stbGo && !stbBusy) begin
                    // invalid code is written anyway; device flags it
                    if (cfgValid(q.cfgPend)) begin
                        d.cfg = q.cfgPend;
                    end
                    d.dqOe = 1'b0;
                    d.stbGo = 1'b1;
                    d.stbRd = 1'b1;
                    d.st = ST_RD;
                end
            end
            ST_RD: begin
                if (stbSample) begin
                    d.sreg = dqSync[7:0];
                    d.raw = dqSync;
                end
                if (!q.stbGo && !stbBusy) begin
                    d.st = ST_DONE;
                end
            end
            ST_DONE: begin
                d.opDone = 1'b1;
                d.st = ST_IDLE;
            end
            default: d.st = ST_IDLE;
        endcase
        if (q.op == fsrsp_pkg::OP_CLEARSR && q.st == ST_DONE) begin
            d.sreg = q.sreg & 8'h80;
        end
        // register read
        d.rdata = '0;
        if (rdEn) begin
            unique case (paddr)
                fsrsp_pkg::OFF_CFG: d.rdata = {24'h000000, q.cfg};
                fsrsp_pkg::OFF_STAT: d.rdata = {q.pulseLen, 8'h00, 3'b000,
                    pinLvl, q.cfgRej, q.opDone, q.st != ST_IDLE, hwResetReq};
                fsrsp_pkg::OFF_SREG: d.rdata = {24'h000000, q.sreg};
                fsrsp_pkg::OFF_RAW: d.rdata = {16'h0000, q.raw};
                default: d.rdata = '0;
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.pinPrev <= 1'b1;
            q.rstPin <= 1'b1;
            q.sreg <= 8'h80;
        end else begin
            q <= d;
        end
    end
    assign prdata = q.rdata;
    assign flashCeN = stbN;
    assign flashWeN = stbN | q.stbRd;
    assign flashOeN = stbN | !q.stbRd;
    assign flashDqOut = q.dq;
    assign flashDqOe = q.dqOe;
    assign flashRstN = q.rstPin;
    // host never reads the array here, so suspended blocks stay untouched

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    a_cfg_needs_ready: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        (q.st == ST_IDLE && wrEn && paddr == fsrsp_pkg::OFF_CTRL &&
         pwdata[3:0] == fsrsp_pkg::OP_CONFIG && !hwResetReq &&
         (!q.sreg[7] || q.sreg[6] || q.sreg[2]))
        |=> q.cfgRej && q.st == ST_IDLE) else $error("config sent while busy");
    a_cfg_no_reserved: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        q.cfg[7:2] == 6'h00) else $error("reserved config bits held");
    a_cfg_no_prog_only: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        q.cfg[1:0] != 2'h2) else $error("unsupported config kept");
    a_reset_clears_cfg: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        hwResetReq |=> q.cfg == 8'h00 && !flashRstN) else $error("reset not applied");
    a_suspend_code: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        (q.st == ST_W1 && q.op == fsrsp_pkg::OP_SUSPEND && !flashWeN)
        |-> flashDqOe && flashDqOut == 16'h00B0) else $error("bad suspend code");
    a_resume_code: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        (q.st == ST_W1 && q.op == fsrsp_pkg::OP_RESUME && !flashWeN)
        |-> flashDqOut == 16'h00D0) else $error("bad resume code");
    a_cfg_two_writes: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        (q.st == ST_W2 && !flashWeN) |-> flashDqOut == {8'h00, q.cfgPend})
        else $error("config data wrong");
    a_setup_code: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        (q.st == ST_W1 && q.op == fsrsp_pkg::OP_CONFIG && !flashWeN)
        |-> flashDqOut == 16'h00B8) else $error("bad config setup");
    a_no_drive_read: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        !flashOeN |-> !flashDqOe) else $error("bus contention");
    c_suspend: cover property (@(posedge clk_sys) q.st == ST_W1 && q.op == fsrsp_pkg::OP_SUSPEND);
    c_resume: cover property (@(posedge clk_sys) q.st == ST_RD && q.op == fsrsp_pkg::OP_RESUME);
    c_config: cover property (@(posedge clk_sys) q.st == ST_W2);
    c_pulse: cover property (@(posedge clk_sys) pinLvl && !q.pinPrev && q.cfg[1:0] != 2'b00);
endmodule

// *** rtl/fsrsp_pkg.sv ***
//----------------------------------------------------------------------
// Behaviour
// - suspend is one write of B0 anywhere
// - never read array in suspended block
// - combined suspend needs two resumes, status clears
// - config is B8 then code, any address
// - configure only when status bit 7 ready
//----------------------------------------------------------------------
package fsrsp_pkg;
    localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
    localparam logic [15:0] CMD_RESUME = 16'h00D0;
    localparam logic [15:0] CMD_CFG_SETUP = 16'h00B8;
    localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
    localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
    localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
    // status bit positions
    localparam int SR_READY = 7;
    localparam int SR_ERS_SUSP = 6;
    localparam int SR_ERR_ERASE = 5;
    localparam int SR_ERR_PROG = 4;
    localparam int SR_PRG_SUSP = 2;
    // host register offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_CFG = 12'h004;
    localparam logic [11:0] OFF_STAT = 12'h008;
    localparam logic [11:0] OFF_SREG = 12'h00C;
    localparam logic [11:0] OFF_RAW = 12'h010;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_FIELD_MASK = 8'h03;
    localparam logic [1:0] CFG_PROG_ONLY = 2'h2;
    // bus strobe and status pulse timing at 100 MHz
    localparam int CLK_NS = 10;
    localparam int WE_LOW_NS = 70;
    localparam int WE_HIGH_NS = 30;
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_NS = 100;
    localparam int RD_CYC = (RD_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_NS = 500;
    localparam int PULSE_CYC = PULSE_NS / CLK_NS;
    localparam logic [3:0] OP_SUSPEND = 4'h1;
    localparam logic [3:0] OP_RESUME = 4'h2;
    localparam logic [3:0] OP_CONFIG = 4'h3;
    localparam logic [3:0] OP_READSR = 4'h4;
    localparam logic [3:0] OP_CLEARSR = 4'h5;
    localparam logic [3:0] OP_RAW = 4'h6;
endpackage

// *** rtl/fsrsp_strobe.sv ***
`timescale 1ns/100ps
module fsrsp_strobe (
    input wire logic clk_sys,
    input wire logic rstSync_n,
    input wire logic start,
    input wire logic isRead,
    output logic busy,
    output logic strobeN,
    output logic sampleNow
);
    //------------------------------------------------------------
    // one bus cycle: strobe low, then recovery high
    //------------------------------------------------------------
    typedef struct packed {
        logic active;
        logic low;
        logic rd;
        logic [7:0] cnt;
    } fsrsp_stb_s;
    fsrsp_stb_s q, d;
    always_comb begin
        d = q;
        sampleNow = 1'b0;
        if (!q.active) begin
            if (start) begin
                d.active = 1'b1;
                d.low = 1'b1;
                d.rd = isRead;
                d.cnt = isRead ? 8'(fsrsp_pkg::RD_CYC) : 8'(fsrsp_pkg::WE_LOW_CYC);
            end
        end else if (q.cnt > 8'h01) begin
            d.cnt = q.cnt - 8'h01;
        end else if (q.low) begin
            sampleNow = q.rd;
            d.low = 1'b0;
            d.cnt = 8'(fsrsp_pkg::WE_HIGH_CYC);
        end else begin
            d.active = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign busy = q.active;
    assign strobeN = !(q.active && q.low);
endmodule

// *** verif/fsrsp_flash_model.sv ***
`timescale 1ns/100ps
module fsrsp_flash_model #(
    parameter int SUSP_NS = 200,
    parameter int PULSE_NS = 500
) (
    input wire logic ceN,
    input wire logic weN,
    input wire logic oeN,
    input wire logic rstN,
    input wire logic [15:0] dqHost,
    input wire logic startErase,
    input wire logic startProg,
    input wire logic finish,
    input wire logic supplyLost,
    output logic [15:0] dqDev,
    output logic stsPin
);
    logic busy = 0, ers = 0, es = 0, ps = 0, cfgNext = 0, pulse = 0, stMode = 1;
    logic [1:0] cfg = 0;
    logic [1:0] errB = 0;
    logic [7:0] sreg;
    logic [15:0] rdVal;
    assign sreg = {!busy, es, errB, 1'h0, ps, 2'h0};
    assign stsPin = (cfg == 2'h0) ? !busy : !pulse;
    assign rdVal = stMode ? {8'h00, sreg} : 16'hA5C3;
    // released bus shows the inverse so a stale value never passes
    assign dqDev = (!ceN && !oeN) ? rdVal : ~rdVal;
    always @(negedge rstN) begin
        busy = 0;
        es = 0;
        ps = 0;
        cfg = 0;
        cfgNext = 0;
        stMode = 1;
    end
    // enable and write strobe rise together; latch on the write edge alone
    always @(posedge weN) if (rstN) begin
        if (cfgNext) begin
            cfgNext = 0;
            if (dqHost[1:0] == 2'h2) errB = 2'h3;
            else cfg = dqHost[1:0];
        end else case (dqHost[7:0])
            8'hB0: if (busy) fork
                begin
                    #SUSP_NS;
                    busy = 0;
                    if (ers) es = 1;
                    else ps = 1;
                end
            join_none
            8'hD0: begin
                stMode = 1;
                if (ps) begin
                    ps = 0;
                    ers = 0;
                    busy = 1;
                end else if (es) begin
                    es = 0;
                    ers = 1;
                    busy = 1;
                end
            end
            8'hB8: cfgNext = 1;
            8'h70: stMode = 1;
            8'h50: errB = 0;
            8'hFF: stMode = 0;
            default: ;
        endcase
    end
    // supply loss while suspended aborts with the matching error bit
    always @(posedge supplyLost) if (es || ps) begin
        errB = es ? 2'h2 : 2'h1;
        es = 0;
        ps = 0;
        ers = 0;
    end
    always @(posedge startErase) if (!busy && !es && !ps) begin
        busy = 1;
        ers = 1;
    end
    always @(posedge startProg) if (!busy && !ps) begin
        busy = 1;
        ers = 0;
    end
    // no lock-bit operations exist here, so every completion may pulse
    always @(posedge finish) if (busy) begin
        busy = 0;
        if (ers ? cfg[0] : cfg[1]) begin
            pulse = 1;
            #PULSE_NS;
            pulse = 0;
        end
    end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, hwResetReq = 0;
    logic startErase = 0, startProg = 0, finish = 0, supplyLost = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, flashCeN, flashWeN, flashOeN, flashRstN, flashDqOe, statusOutPin;
    logic [15:0] flashDqOut, flashDqIn;
    logic [7:0] lfsr = 8'h33;
    logic [1:0] codes [3] = '{2'h3, 2'h2, 2'h1};
    int num_errors = 0, n_compared = 0, expCfg = 0;
    initial forever #5 clk_sys = ~clk_sys;
    fsrsp_host i_fsrsp_host (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
        .flashRstN(flashRstN), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
        .flashDqIn(flashDqIn), .statusOutPin(statusOutPin), .hwResetReq(hwResetReq));
    fsrsp_flash_model i_fsrsp_flash_model (.ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN),
        .rstN(flashRstN), .dqHost(flashDqOut), .startErase(startErase),
        .startProg(startProg), .finish(finish), .supplyLost(supplyLost),
        .dqDev(flashDqIn), .stsPin(statusOutPin));
    //--------------------------------------------------
    // bus and check helpers
    //--------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        @(posedge clk_sys);
        while (pready !== 1'h1) @(posedge clk_sys);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic logic [7:0] nextLfsr(input logic [7:0] s);
        nextLfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic doOp(input logic [3:0] op);
        apb(1'h1, fsrsp_pkg::OFF_CTRL, {28'h0, op});
        repeat (2) @(posedge clk_sys);
        rd = 32'h0;
        while (rd[2] !== 1'h1 || rd[1] !== 1'h0) apb(1'h0, fsrsp_pkg::OFF_STAT, 32'h0);
    endtask
    // status only, array never read while suspended
    task automatic sreg(input string what, input logic [7:0] exp);
        doOp(fsrsp_pkg::OP_READSR);
        apb(1'h0, fsrsp_pkg::OFF_SREG, 32'h0);
        check(what, {24'h0, exp}, {24'h0, rd[7:0]});
    endtask
    task automatic kick(input int which);
        @(posedge clk_sys);
        if (which == 0) startErase <= 1'h1;
        else if (which == 1) startProg <= 1'h1;
        else finish <= 1'h1;
        @(posedge clk_sys);
        {startErase, startProg, finish} <= 3'h0;
        repeat (30) @(posedge clk_sys);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    //--------------------------------------------------
    // sequence
    //--------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk_sys);
        apb(1'h0, fsrsp_pkg::OFF_CFG, 32'h0);
        check("cfg reset", 32'h0, rd);
        apb(1'h0, 12'h020, 32'h0);
        check("unmapped err", 32'h0, {31'h0, pslverr});
        $display("test reset done");
        kick(0);
        apb(1'h0, fsrsp_pkg::OFF_STAT, 32'h0);
        check("pin busy", 32'h0, {31'h0, rd[4]});
        doOp(fsrsp_pkg::OP_SUSPEND);
        repeat (30) @(posedge clk_sys);
        sreg("erase susp", 8'hC0);
        apb(1'h0, fsrsp_pkg::OFF_STAT, 32'h0);
        check("pin susp", 32'h1, {31'h0, rd[4]});
        apb(1'h1, fsrsp_pkg::OFF_CFG, 32'h3);
        doOp(fsrsp_pkg::OP_CONFIG);
        check("cfg refused", 32'h1, {31'h0, rd[3]});
        kick(1);
        doOp(fsrsp_pkg::OP_SUSPEND);
        repeat (30) @(posedge clk_sys);
        sreg("both susp", 8'hC4);
        doOp(fsrsp_pkg::OP_RESUME);
        sreg("prog resumed", 8'h40);
        kick(2);
        doOp(fsrsp_pkg::OP_CLEARSR);
        sreg("prog done", 8'hC0);
        doOp(fsrsp_pkg::OP_RESUME);
        sreg("erase resumed", 8'h00);
        kick(2);
        sreg("all done", 8'h80);
        apb(1'h0, fsrsp_pkg::OFF_RAW, 32'h0);
        check("raw word", 32'h80, rd);
        $display("test suspend done");
        foreach (codes[i]) begin
            lfsr = nextLfsr(lfsr);
            apb(1'h1, fsrsp_pkg::OFF_CFG, {24'h0, lfsr[7:2], codes[i]});
            doOp(fsrsp_pkg::OP_CONFIG);
            if (codes[i] == 2'h2) begin
                sreg("cfg invalid", 8'hB0);
                doOp(fsrsp_pkg::OP_CLEARSR);
            end else begin
                expCfg = codes[i];
                kick(0);
                kick(2);
                repeat (60) @(posedge clk_sys);
                apb(1'h0, fsrsp_pkg::OFF_STAT, 32'h0);
                check("pulse len", 32'h1, {31'h0, rd[31:16] >= 48 && rd[31:16] <= 52});
            end
            apb(1'h0, fsrsp_pkg::OFF_CFG, 32'h0);
            check("cfg kept", expCfg, {30'h0, rd[1:0]});
        end
        $display("test config done");
        kick(0);
        doOp(fsrsp_pkg::OP_SUSPEND);
        repeat (30) @(posedge clk_sys);
        supplyLost <= 1'h1;
        @(posedge clk_sys);
        supplyLost <= 1'h0;
        sreg("abort by supply", 8'hA0);
        doOp(fsrsp_pkg::OP_CLEARSR);
        $display("test supply loss done");
        kick(0);
        doOp(fsrsp_pkg::OP_SUSPEND);
        repeat (30) @(posedge clk_sys);
        hwResetReq <= 1'h1;
        repeat (5) @(posedge clk_sys);
        apb(1'h0, fsrsp_pkg::OFF_STAT, 32'h0);
        check("reset flag", 32'h1, {31'h0, rd[0]});
        hwResetReq <= 1'h0;
        repeat (5) @(posedge clk_sys);
        apb(1'h0, fsrsp_pkg::OFF_CFG, 32'h0);
        check("cfg after reset", 32'h0, {30'h0, rd[1:0]});
        sreg("abort by reset", 8'h80);
        $display("test hw reset done");
        close_out();
    end
    initial begin
        #500000;
        num_errors++;
        close_out();
    end
endmodule
